// ==== mbr_defines.svh ====
`ifndef MBR_DEFINES_SVH
`define MBR_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL      5'h00
`define OFS_PRIM      5'h04
`define OFS_BACK      5'h08
`define OFS_STAT      5'h0C
`define OFS_CMD       5'h10
`define OFS_LOCK      5'h14

// Interleave codes
`define IL_ONE        2'h0
`define IL_TWO64      2'h1
`define IL_TWO128     2'h2
`define IL_FOUR       2'h3

// Command bits
`define CMD_RETRY_GO  0
`define CMD_RETRY_END 1
`define CMD_SWITCH    2
`define CMD_CLR_ERR   3

// Pair partner differs in the middle bit of the bus number
`define PAIR_MASK     3'h2

// Range fields: start in low half, end in high half, 64 KB units
`define RNG_LO        15:0
`define RNG_HI        31:16

`define ZERO32        32'h0000_0000
`endif

// ==== mbr_pkg.sv ====
package mbr_pkg;

  typedef enum logic [2:0] {
    SPLIT_IDLE   = 3'b001,
    SPLIT_PEND   = 3'b010,
    SPLIT_CANCEL = 3'b100
  } split_state_type;

  typedef struct packed {
    logic [3:0] nbus;
    logic       redund;
    logic [2:0] bus_id;
    logic       back_en;
    logic       prim_en;
    logic [1:0] intl;
  } ctrl_type;

  typedef struct packed {
    ctrl_type        ctrl;
    logic [31:0]     prim_rng;
    logic [31:0]     back_rng;
    logic            grow_ok;
    logic            retry;
    logic            sel;
    logic            lock;
    logic [31:0]     lock_addr;
    logic            cfg_err;
    logic            rng_err;
    logic [31:0]     req_addr;
    logic            match;
    logic [2:0]      tbus;
    logic [31:0]     baddr;
    split_state_type sst;
    logic [1:0]      drive;
    logic [1:0]      done;
    logic [1:0]      seen_low;
    logic            accept;
    logic            wait_r;
    logic [31:0]     rdata;
  } state_type;

endpackage

// ==== memory_bus_redundancy_support.sv ====
// Notes on behaviour
// - Interleave only reorders address bits, never drops
// - Primary and backup ranges, each separately enabled
// - Recompute recognition for requests retried during retry
// - Record completion status of split bus accesses
// - Split lines low at start, released per half
// - Invalidating error pulses tracking lines one cycle
// - Monitor both lines, keep completion state
// - One active bus connection, chosen by select
// - Bus connection switches only inside retry sequence
// - RMW lock stays with array across switch
// - Each bus request accepted by one unit
// - Range grows only in recovery, after leaving four-way, or while disabled
// - Fixed pairs: 0/2, 1/3, 4/6, 5/7
// - Legal redundancy options depend on bus count
// - Two-bus redundant one-way system never both active
// - Two-way 64-byte alternates buses 0 and 1
// - Two-way 128-byte alternates buses 0 and 2
// - Four-way split hits both modules of each pair
// - Interleave codes 00,01,10,11 as documented
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "mbr_defines.svh"
`default_nettype none

module memory_bus_redundancy_support
  import mbr_pkg::*;
(
  input  wire logic        clk_in,                     // 100 MHz clock
  input  wire logic        rstn_in,                    // Sync reset, low
  input  wire logic [4:0]  address_in,                 // Byte address
  input  wire logic        read_in,                    // Read strobe
  input  wire logic        write_in,                   // Write strobe
  input  wire logic [31:0] writedata_in,               // Write data
  output logic      [31:0] readdata_out,               // Read data
  output logic             waitrequest_out,            // Stall, high
  input  wire logic        req_valid_in,               // Processor request
  input  wire logic [31:0] req_addr_in,                // Processor address
  output logic             req_match_out,              // Range hit
  output logic      [2:0]  req_bus_out,                // Target bus
  output logic      [31:0] req_bus_addr_out,           // Reordered address
  input  wire logic        split_start_in,             // Split access begins
  input  wire logic [1:0]  split_half_done_in,         // {high,low} finished
  input  wire logic        error_report_in,            // Invalidating error
  input  wire logic        split_high_pending_n_in,    // Line level
  output logic             split_high_pending_n_out,   // Drive value
  output logic             split_high_pending_n_oe_out,// Drive enable
  input  wire logic        split_low_pending_n_in,     // Line level
  output logic             split_low_pending_n_out,    // Drive value
  output logic             split_low_pending_n_oe_out, // Drive enable
  input  wire logic [1:0]  mem_req_in,                 // Request per bus port
  output logic             mem_accept_out,             // Request taken
  output logic             active_bus_select_out,      // Active connection
  input  wire logic        rmw_lock_in,                // Lock array word
  input  wire logic        rmw_unlock_in,              // Release lock
  input  wire logic [31:0] rmw_addr_in                 // Locked address
);

  state_type s_q;
  state_type s_d;

  // Bus-select bits move to the top; the bits above them shift down intact, the bits below stay put
  function automatic logic [31:0] permute(input logic [31:0] a, input logic [1:0] il);
    case (il)
      `IL_TWO64:  permute = {a[6], a[31:7], a[5:0]};
      `IL_TWO128: permute = {a[7], a[31:8], a[6:0]};
      `IL_FOUR:   permute = {a[7:6], a[31:8], a[5:0]};
      default:    permute = a;
    endcase
  endfunction

  function automatic logic [2:0] tgt_bus(input logic [31:0] a, input logic [1:0] il,
                                         input logic [2:0] id);
    case (il)
      `IL_TWO64:  tgt_bus = {id[2], 1'b0, a[6]};
      `IL_TWO128: tgt_bus = {id[2], a[7], 1'b0};
      `IL_FOUR:   tgt_bus = {id[2], a[7:6]};
      default:    tgt_bus = id;
    endcase
  endfunction

  function automatic logic [2:0] partner(input logic [2:0] id);
    partner = id ^ `PAIR_MASK;
  endfunction

  function automatic logic in_range(input logic [15:0] a, input logic [31:0] r);
    in_range = (a >= r[`RNG_LO]) && (a <= r[`RNG_HI]);
  endfunction

  function automatic logic [16:0] span(input logic [31:0] r);
    span = {1'b0, r[`RNG_HI]} - {1'b0, r[`RNG_LO]};
  endfunction

  // Table of permitted redundancy set-ups
  function automatic logic cfg_legal(input ctrl_type c);
    cfg_legal = 1'b1;
    if (c.redund) begin
      case (c.nbus)
        4'h2:    cfg_legal = (c.intl == `IL_ONE) ? !(c.prim_en && c.back_en)
                             : (c.intl == `IL_TWO128);
        4'h4:    cfg_legal = (c.intl != `IL_TWO128);
        4'h6,
        4'h8:    cfg_legal = 1'b1;
        default: cfg_legal = 1'b0;
      endcase
    end
  endfunction

  logic        acc;
  logic        wr;
  logic [31:0] baddr_c;
  logic [31:0] grow_c;
  logic [1:0]  line_c;
  ctrl_type    new_ctrl;

  assign acc      = (read_in || write_in) && s_q.wait_r;
  assign wr       = acc && write_in;
  assign new_ctrl = ctrl_type'(writedata_in[11:0]);
  assign line_c   = {split_high_pending_n_in, split_low_pending_n_in};
  assign baddr_c  = permute(s_q.req_addr, s_q.ctrl.intl);
  assign grow_c   = writedata_in;

  always_comb begin
    s_d = s_q;
    // Avalon slave: one wait cycle, then a single low pulse on waitrequest
    s_d.wait_r = !acc;
    s_d.rdata  = `ZERO32;
    if (acc && read_in) begin
      case (address_in)
        `OFS_CTRL: s_d.rdata = {20'h0_0000, s_q.ctrl};
        `OFS_PRIM: s_d.rdata = s_q.prim_rng;
        `OFS_BACK: s_d.rdata = s_q.back_rng;
        `OFS_STAT: s_d.rdata = {14'h0000, s_q.tbus, partner(s_q.ctrl.bus_id),
                                s_q.rng_err, s_q.cfg_err, s_q.seen_low, s_q.done,
                                s_q.drive, s_q.match, s_q.lock, s_q.retry, s_q.sel};
        `OFS_LOCK: s_d.rdata = s_q.lock_addr;
        default:   s_d.rdata = `ZERO32;
      endcase
    end

    if (wr && address_in == `OFS_CMD && writedata_in[`CMD_CLR_ERR]) begin
      s_d.cfg_err = 1'b0;
      s_d.rng_err = 1'b0;
    end

    if (wr && address_in == `OFS_CTRL) begin
      if (cfg_legal(new_ctrl)) begin
        // Leaving four-way widens each bus's space once
        if (s_q.ctrl.intl == `IL_FOUR && new_ctrl.intl != `IL_FOUR)
          s_d.grow_ok = 1'b1;
        s_d.ctrl = new_ctrl;
      end else begin
        s_d.cfg_err = 1'b1;
      end
    end

    // A range may shrink any time but grows only when permitted
    if (wr && address_in == `OFS_PRIM) begin
      if (s_q.retry || s_q.grow_ok || !s_q.ctrl.prim_en ||
          span(grow_c) <= span(s_q.prim_rng)) begin
        s_d.prim_rng = writedata_in;
        s_d.grow_ok  = 1'b0;
      end else begin
        s_d.rng_err = 1'b1;
      end
    end
    if (wr && address_in == `OFS_BACK) begin
      if (s_q.retry || s_q.grow_ok || !s_q.ctrl.back_en ||
          span(grow_c) <= span(s_q.back_rng)) begin
        s_d.back_rng = writedata_in;
        s_d.grow_ok  = 1'b0;
      end else begin
        s_d.rng_err = 1'b1;
      end
    end

    if (wr && address_in == `OFS_CMD) begin
      if (writedata_in[`CMD_RETRY_GO])
        s_d.retry = 1'b1;
      if (writedata_in[`CMD_RETRY_END])
        s_d.retry = 1'b0;
      // Switching outside retry could drop an access in flight
      if (writedata_in[`CMD_SWITCH] && s_q.retry)
        s_d.sel = !s_q.sel;
    end

    // Lock lives here, not on the bus, so it survives a switch
    if (rmw_unlock_in)
      s_d.lock = 1'b0;
    if (rmw_lock_in) begin
      s_d.lock      = 1'b1;
      s_d.lock_addr = rmw_addr_in;
    end

    // Only the active connection can deliver a request here
    s_d.accept = mem_req_in[s_q.sel];

    // Held request is re-evaluated every cycle, so retries see new config
    if (req_valid_in)
      s_d.req_addr = req_addr_in;
    s_d.baddr = baddr_c;
    s_d.tbus  = tgt_bus(s_q.req_addr, s_q.ctrl.intl, s_q.ctrl.bus_id);
    s_d.match = (s_q.ctrl.prim_en && in_range(baddr_c[31:16], s_q.prim_rng)) ||
                (s_q.ctrl.back_en && in_range(baddr_c[31:16], s_q.back_rng));

    // Lines released by any unit after being low mark that half complete
    s_d.seen_low = ~line_c;
    s_d.done     = s_q.done | (s_q.seen_low & line_c);

    case (s_q.sst)
      SPLIT_IDLE: begin
        s_d.drive = 2'b00;
        if (split_start_in) begin
          s_d.drive = 2'b11;
          s_d.done  = 2'b00;
          s_d.sst   = SPLIT_PEND;
        end
      end
      SPLIT_PEND: begin
        s_d.drive = s_q.drive & ~split_half_done_in;
        s_d.done  = s_d.done | split_half_done_in;
        if (error_report_in) begin
          s_d.drive = 2'b00;
          s_d.sst   = SPLIT_CANCEL;
        end else if (s_d.drive == 2'b00) begin
          s_d.sst = SPLIT_IDLE;
        end
      end
      SPLIT_CANCEL: begin
        s_d.drive = 2'b11;
        s_d.done  = 2'b00;
        s_d.sst   = SPLIT_IDLE;
      end
      default: begin
        s_d.drive = 2'b00;
        s_d.sst   = SPLIT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_q        <= '0;
      s_q.wait_r <= 1'b1;
      s_q.sst    <= SPLIT_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata_out                = s_q.rdata;
  assign waitrequest_out             = s_q.wait_r;
  assign req_match_out               = s_q.match;
  assign req_bus_out                 = s_q.tbus;
  assign req_bus_addr_out            = s_q.baddr;
  // Open-drain lines: the drive value stays low and the enable carries the state
  assign split_high_pending_n_out    = 1'b0;
  assign split_high_pending_n_oe_out = s_q.drive[1];
  assign split_low_pending_n_out     = 1'b0;
  assign split_low_pending_n_oe_out  = s_q.drive[0];
  assign mem_accept_out              = s_q.accept;
  assign active_bus_select_out       = s_q.sel;

  // Checks
  perm_bits_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $countones(req_bus_addr_out) == $countones($past(s_q.req_addr)))
    else $error("Reordered address lost or gained bits");

  range_hit_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !s_q.ctrl.prim_en && !s_q.ctrl.back_en |=> !req_match_out)
    else $error("Match with both ranges disabled");

  retry_recalc_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.retry && $stable(s_q.ctrl) && !req_valid_in |-> ##2
      req_bus_out == tgt_bus($past(s_q.req_addr, 2), $past(s_q.ctrl.intl),
                             $past(s_q.ctrl.bus_id)))
    else $error("Target bus not recomputed");

  split_start_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.sst == SPLIT_IDLE && split_start_in |=>
      split_high_pending_n_oe_out && split_low_pending_n_oe_out)
    else $error("Split lines not driven at start");

  cancel_pulse_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.sst == SPLIT_PEND && error_report_in |=> ##1
      (split_high_pending_n_oe_out && split_low_pending_n_oe_out) ##1
      (!split_high_pending_n_oe_out && !split_low_pending_n_oe_out))
    else $error("Cancel pulse not one cycle");

  half_done_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !split_low_pending_n_in ##1 split_low_pending_n_in && s_q.sst != SPLIT_CANCEL
      && !(s_q.sst == SPLIT_IDLE && split_start_in) |=> s_q.done[0])
    else $error("Low half completion missed");

  one_conn_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    mem_accept_out |-> $past(mem_req_in[active_bus_select_out]))
    else $error("Accepted from inactive bus");

  switch_retry_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $changed(active_bus_select_out) |-> $past(s_q.retry))
    else $error("Bus switched outside retry");

  lock_keep_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $changed(active_bus_select_out) && $past(s_q.lock) && !$past(rmw_unlock_in)
      |-> s_q.lock)
    else $error("Lock lost on bus switch");

  wait_ack_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (read_in || write_in) && waitrequest_out |=> !waitrequest_out ##1 waitrequest_out)
    else $error("Bus answer not one cycle");

  cfg_refuse_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr && address_in == `OFS_CTRL && !cfg_legal(new_ctrl) |=>
      s_q.cfg_err && $stable(s_q.ctrl))
    else $error("Illegal configuration was taken");

  spare_bus_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.ctrl.redund && s_q.ctrl.nbus == 4'h2 && s_q.ctrl.intl == `IL_ONE
      |-> !(s_q.ctrl.prim_en && s_q.ctrl.back_en))
    else $error("Both ranges live on a spare pair");

  grow_block_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr && address_in == `OFS_PRIM && !s_q.retry && !s_q.grow_ok && s_q.ctrl.prim_en &&
      span(writedata_in) > span(s_q.prim_rng) |=> $stable(s_q.prim_rng) && s_q.rng_err)
    else $error("Primary range grew outside recovery");

  split_idle_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.sst == SPLIT_IDLE && !split_start_in |=>
      !split_high_pending_n_oe_out && !split_low_pending_n_oe_out)
    else $error("Split line held while idle");

  half_release_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.sst == SPLIT_PEND && !error_report_in && split_half_done_in[0] |=>
      !split_low_pending_n_oe_out)
    else $error("Low line kept after its half");

  half_record_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.sst == SPLIT_PEND && !error_report_in && split_half_done_in[0] |=> s_q.done[0])
    else $error("Low half completion not recorded");

  two64_bus_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.ctrl.intl == `IL_TWO64 |=> !req_bus_out[1])
    else $error("Two-way 64 left buses 0 and 1");

  two128_bus_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.ctrl.intl == `IL_TWO128 |=> !req_bus_out[0])
    else $error("Two-way 128 left buses 0 and 2");

  four_way_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.ctrl.intl == `IL_FOUR |=> req_bus_out[1:0] == $past(s_q.req_addr[7:6]))
    else $error("Four-way split missed a pair");

  one_way_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.ctrl.intl == `IL_ONE |=> req_bus_out == $past(s_q.ctrl.bus_id))
    else $error("One-way request left own bus");

  lock_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    rmw_lock_in |=> s_q.lock && s_q.lock_addr == $past(rmw_addr_in))
    else $error("Lock not taken");

  accept_port_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !mem_req_in[s_q.sel] |=> !mem_accept_out)
    else $error("Accepted without request on active bus");

  split_cov: cover property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.sst == SPLIT_PEND ##[1:20] s_q.sst == SPLIT_IDLE);
  cancel_cov: cover property (@(posedge clk_in) disable iff (!rstn_in)
    s_q.sst == SPLIT_CANCEL);
  switch_cov: cover property (@(posedge clk_in) disable iff (!rstn_in)
    $changed(active_bus_select_out) && s_q.lock);
  grow_cov: cover property (@(posedge clk_in) disable iff (!rstn_in)
    wr && address_in == `OFS_PRIM && s_q.grow_ok);
  refuse_cov: cover property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(s_q.cfg_err));

endmodule

`default_nettype wire

// ==== memory_bus_redundancy_support_test.sv ====
`timescale 1ns/1ps
`include "mbr_defines.svh"
`default_nettype none

module memory_bus_redundancy_support_test;
  logic        clk_in, rstn_in, read_in, write_in, req_valid_in, split_start_in;
  logic        error_report_in, rmw_lock_in, rmw_unlock_in, waitrequest_out;
  logic        req_match_out, mem_accept_out, active_bus_select_out;
  logic [4:0]  address_in;
  logic [31:0] writedata_in, req_addr_in, rmw_addr_in, readdata_out, req_bus_addr_out, rdata;
  logic [2:0]  req_bus_out;
  logic [1:0]  split_half_done_in, mem_req_in, oe, line_n, peer, drv;
  logic [3:0]  blips;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cycles = 0;

  memory_bus_redundancy_support dut_u (
    .clk_in, .rstn_in, .address_in, .read_in, .write_in, .writedata_in, .readdata_out,
    .waitrequest_out, .req_valid_in, .req_addr_in, .req_match_out, .req_bus_out,
    .req_bus_addr_out, .split_start_in, .split_half_done_in, .error_report_in,
    .split_high_pending_n_in(line_n[1]), .split_high_pending_n_out(drv[1]),
    .split_high_pending_n_oe_out(oe[1]), .split_low_pending_n_in(line_n[0]),
    .split_low_pending_n_out(drv[0]), .split_low_pending_n_oe_out(oe[0]), .mem_req_in,
    .mem_accept_out, .active_bus_select_out, .rmw_lock_in, .rmw_unlock_in, .rmw_addr_in
  );

  split_line_partner peer_u (
    .clk_in, .rstn_in, .dut_oe_in(oe & ~drv), .peer_in(peer), .line_n_out(line_n),
    .blips_out(blips)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low; only the timeout ends a hang
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    address_in <= a;
    writedata_in <= d;
    write_in <= wr;
    read_in <= !wr;
    do @(posedge clk_in); while (waitrequest_out !== 1'b0);
    rdata = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic req(input logic [31:0] a);
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_addr_in <= a;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    tick(2);
  endtask

  task automatic t_mem;
    @(posedge clk_in);
    mem_req_in <= 2'h2;
    tick(2);
    check_bit("accept idle port", 1'b0, mem_accept_out);
    mem_req_in <= 2'h3;
    tick(2);
    check_bit("accept active port", 1'b1, mem_accept_out);
    mem_req_in <= 2'h0;
    wr(`OFS_CMD, 32'h0000_0004);
    check_bit("select outside retry", 1'b0, active_bus_select_out);
    $display("test mem done");
  endtask

  task automatic t_split;
    @(posedge clk_in);
    peer <= 2'h3;
    tick(4);
    peer <= 2'h0;
    tick(3);
    rd(`OFS_STAT);
    check_word("done bits", 32'h0000_0003, {30'h0, rdata[7:6]});
    @(posedge clk_in);
    split_start_in <= 1'b1;
    @(posedge clk_in);
    split_start_in <= 1'b0;
    tick(1);
    check_word("start drive", 32'h0000_0003, {30'h0, oe});
    check_word("drive level", 32'h0000_0000, {30'h0, drv});
    check_word("lines pending", 32'h0000_0000, {30'h0, line_n});
    split_half_done_in <= 2'h1;
    @(posedge clk_in);
    split_half_done_in <= 2'h0;
    tick(1);
    check_word("low half released", 32'h0000_0002, {30'h0, oe});
    error_report_in <= 1'b1;
    @(posedge clk_in);
    error_report_in <= 1'b0;
    tick(1);
    check_word("cancel gap", 32'h0000_0000, {30'h0, oe});
    tick(1);
    check_word("cancel pulse", 32'h0000_0003, {30'h0, oe});
    tick(1);
    check_word("after cancel", 32'h0000_0000, {30'h0, oe});
    tick(2);
    check_word("pulses on lines", 32'h0000_0002, {28'h0, blips});
    $display("test split done");
  endtask

  task automatic t_range;
    wr(`OFS_CTRL, 32'h0000_0100);
    wr(`OFS_PRIM, 32'h0020_0010);
    wr(`OFS_BACK, 32'h0040_0030);
    wr(`OFS_CTRL, 32'h0000_010C);
    req(32'h0015_0000);
    check_bit("primary hit", 1'b1, req_match_out);
    req(32'h0035_0000);
    check_bit("backup hit", 1'b1, req_match_out);
    req(32'h0050_0000);
    check_bit("outside ranges", 1'b0, req_match_out);
    wr(`OFS_CTRL, 32'h0000_0108);
    req(32'h0015_0000);
    check_bit("primary disabled", 1'b0, req_match_out);
    wr(`OFS_CTRL, 32'h0000_010C);
    wr(`OFS_PRIM, 32'h0030_0010);
    rd(`OFS_STAT);
    check_bit("growth refused", 1'b1, rdata[11]);
    rd(`OFS_PRIM);
    check_word("primary kept", 32'h0020_0010, rdata);
    wr(`OFS_CMD, 32'h0000_0008);
    wr(`OFS_CMD, 32'h0000_0001);
    wr(`OFS_PRIM, 32'h0030_0010);
    rd(`OFS_PRIM);
    check_word("growth in retry", 32'h0030_0010, rdata);
    req(32'h0025_0000);
    check_bit("retried request hit", 1'b1, req_match_out);
    rmw_addr_in <= 32'h1234_5670;
    rmw_lock_in <= 1'b1;
    @(posedge clk_in);
    rmw_lock_in <= 1'b0;
    wr(`OFS_CMD, 32'h0000_0004);
    check_bit("select in retry", 1'b1, active_bus_select_out);
    rd(`OFS_STAT);
    check_bit("lock kept", 1'b1, rdata[2]);
    rd(`OFS_LOCK);
    check_word("lock address", 32'h1234_5670, rdata);
    wr(`OFS_CMD, 32'h0000_0002);
    @(posedge clk_in);
    mem_req_in <= 2'h2;
    tick(2);
    check_bit("accept new port", 1'b1, mem_accept_out);
    mem_req_in <= 2'h1;
    tick(2);
    check_bit("old port ignored", 1'b0, mem_accept_out);
    mem_req_in <= 2'h0;
    rmw_unlock_in <= 1'b1;
    @(posedge clk_in);
    rmw_unlock_in <= 1'b0;
    rd(`OFS_STAT);
    check_bit("lock released", 1'b0, rdata[2]);
    wr(`OFS_CTRL, 32'h0000_010F);
    wr(`OFS_CTRL, 32'h0000_010D);
    wr(`OFS_PRIM, 32'h0040_0010);
    rd(`OFS_PRIM);
    check_word("growth after four-way", 32'h0040_0010, rdata);
    wr(`OFS_PRIM, 32'h0050_0010);
    rd(`OFS_STAT);
    check_bit("second growth refused", 1'b1, rdata[11]);
    $display("test range done");
  endtask

  task automatic t_intl;
    logic [1:0] il [6] = '{`IL_ONE, `IL_TWO64, `IL_TWO64, `IL_TWO128, `IL_TWO128, `IL_FOUR};
    logic [7:0] ad [6] = '{8'hC0, 8'h40, 8'h80, 8'h80, 8'h40, 8'hC0};
    logic [2:0] bu [6] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h0, 3'h3};
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_CTRL, {30'h40, il[i]});
      req({24'h00_0100, ad[i]});
      check_word("target bus", {29'h0, bu[i]}, {29'h0, req_bus_out});
      check_word("bit count", 32'($countones({24'h00_0100, ad[i]})),
                 32'($countones(req_bus_addr_out)));
    end
    $display("test interleave done");
  endtask

  task automatic t_pair;
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_CTRL, 32'h0000_0100 | (32'(i) << 4));
      rd(`OFS_STAT);
      check_word("partner bus", 32'(i ^ 2), {29'h0, rdata[14:12]});
    end
    $display("test pairing done");
  endtask

  task automatic t_cfg;
    logic [11:0] cv [7] = '{12'h28C, 12'h380, 12'h180, 12'h284, 12'h483, 12'h482, 12'h282};
    logic        ce [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 7; i++) begin
      wr(`OFS_CTRL, 32'h0000_0100);
      wr(`OFS_CMD, 32'h0000_0008);
      wr(`OFS_CTRL, {20'h0, cv[i]});
      rd(`OFS_STAT);
      check_bit("config refused", ce[i], rdata[10]);
      rd(`OFS_CTRL);
      check_word("control value", ce[i] ? 32'h0000_0100 : {20'h0, cv[i]}, rdata);
    end
    $display("test config done");
  endtask

  task automatic results;
    $display("counts compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    {rstn_in, read_in, write_in, req_valid_in, split_start_in, error_report_in} = '0;
    {rmw_lock_in, rmw_unlock_in, address_in, writedata_in, req_addr_in, rmw_addr_in} = '0;
    {split_half_done_in, mem_req_in, peer} = '0;
    tick(3);
    rstn_in <= 1'b1;
    t_mem();
    t_split();
    t_range();
    t_intl();
    t_pair();
    t_cfg();
    results();
  end
endmodule

`default_nettype wire

// ==== split_line_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

module split_line_partner (
  input  wire logic       clk_in,     // Clock
  input  wire logic       rstn_in,    // Reset, low
  input  wire logic [1:0] dut_oe_in,  // Device pulls {hi,lo}
  input  wire logic [1:0] peer_in,    // Peer unit pulls {hi,lo}
  output logic      [1:0] line_n_out, // Resolved line levels
  output logic      [3:0] blips_out   // One-cycle lows seen
);
  logic [1:0] prev_q;
  logic [1:0] pp_q;

  // Pull-ups hold a line high while nobody pulls it
  assign line_n_out = ~(dut_oe_in | peer_in);

  // Watches both lines for one-cycle cancel pulses
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      prev_q <= 2'h3;
      pp_q <= 2'h3;
      blips_out <= 4'h0;
    end else begin
      prev_q <= line_n_out;
      pp_q <= prev_q;
      blips_out <= blips_out + 4'($countones(~prev_q & pp_q & line_n_out));
    end
  end
endmodule

`default_nettype wire
